// *** inc/boot_ctrl_pkg.sv ***
// Purpose: Shared constants and carriers for the dual subsystem memory and
//          boot control block.
// Assumes: 16-bit data words, 18-bit external program addresses.
// Notes: Register offsets are byte addresses on a 32-bit APB.
package boot_ctrl_pkg;

  // APB register offsets.
  localparam logic [7:0] processor_mode_status_a_off = 8'h00;
  localparam logic [7:0] processor_mode_status_b_off = 8'h04;
  localparam logic [7:0] status_off = 8'h08;
  localparam logic [7:0] ctrl_off = 8'h0C;

  // Mode register field positions.
  localparam int vec_ptr_lsb = 7;
  localparam int map_sel_bit = 6;
  localparam int overlay_bit = 5;
  localparam int data_view_bit = 3;

  // Mode register reset value apart from the strapped map select bit.
  localparam logic [15:0] processor_mode_status_reset = 16'hFF80;

  // Address map bounds, 18-bit program and 16-bit data.
  localparam logic [15:0] dual_lo = 16'h0060;
  localparam logic [15:0] dual_hi = 16'h3FFF;
  localparam logic [15:0] sa1_lo = 16'h4000;
  localparam logic [15:0] sa1_hi = 16'h7FFF;
  localparam logic [15:0] sa2_lo = 16'h8000;
  localparam logic [17:0] pgm_only1_lo = 18'h18000;
  localparam logic [17:0] pgm_only1_hi = 18'h1FFFF;
  localparam logic [17:0] pgm_only2_lo = 18'h2F000;
  localparam logic [17:0] pgm_only2_hi = 18'h2FFFF;
  localparam logic [17:0] reset_vector = 18'h0FF80;
  localparam logic [15:0] release_addr = 16'h002F;

  // Host port wait after its reset rises.
  localparam int host_wait_cycles = 3;

  // One memory request from a subsystem core.
  typedef struct packed {
    logic valid;
    logic [1:0] space;   // 0 program, 1 data, 2 io
    logic write;
    logic [17:0] addr;
  } mem_req_type;

  // Routing result for one request.
  typedef struct packed {
    logic internal;
    logic external;
    logic io_strobe;
  } mem_route_type;

  localparam logic [1:0] space_prog = 2'h0;
  localparam logic [1:0] space_data = 2'h1;
  localparam logic [1:0] space_io = 2'h2;

  typedef enum logic [1:0] {
    core_held = 2'b00,
    core_fetch = 2'b01,
    core_run = 2'b10
  } core_state_type;

endpackage

// *** hw/boot_ctrl.sv ***
// Purpose: Memory map decode, shared interface ownership and reset/boot
//          sequencing for two processor subsystems.
// Assumes: All pins but rst synchronous to clk; APB slave for mode registers.
// Notes: Core internals are outside; this block routes and sequences.
`timescale 1ns/1ns

// Overview of operation
// - Each subsystem: program, data, io spaces.
// - Dual access RAM in data space.
// - Low single RAM overlays program when enabled.
// - Upper single RAM joins data when viewed.
// - Two program ranges never served as data.
// - Four program pages on eighteen address lines.
// - Data outside on-chip RAM goes external.
// - Owner I/O accesses raise io space strobe in memory mode.
// - Owner select low gives A, high B.
// - Interface select high memory, low host port.
// - Mode register holds pointer, map, overlay, view.
// - Map select routes upper program page half.
// - Overlay and view bits map RAM blocks.
// - Map select strapped from pins at reset.
// - Subsystem resets; A also resets clock mode.
// - Cores fetch reset vector at FF80.
// - Write to 2F releases selected held subsystem.
// - Master loads slave through its host port.
// - Lockstep boot forbids external writes.
module boot_ctrl
  import boot_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic external_memory_interface_owner_select,
  input wire logic external_memory_interface_hpi_select,
  input wire logic host_port_mux_mode,
  input wire logic subsystem_a_reset_n,
  input wire logic subsystem_b_reset_n,
  input wire logic host_port_reset_n,
  input wire logic host_write,
  input wire logic [15:0] host_addr,
  input wire boot_ctrl_pkg::mem_req_type req_a,
  input wire boot_ctrl_pkg::mem_req_type req_b,
  output boot_ctrl_pkg::mem_route_type route_a,
  output boot_ctrl_pkg::mem_route_type route_b,
  output logic ext_valid,
  output logic ext_write,
  output logic [17:0] ext_addr,
  output logic ext_is_io,
  output logic io_space_strobe,
  output logic host_port_active,
  output logic host_port_ready,
  output logic core_a_running,
  output logic core_b_running,
  output logic [17:0] core_a_fetch_addr,
  output logic [17:0] core_b_fetch_addr,
  output logic clock_bypass
);

  typedef struct packed {
    logic [15:0] processor_mode_status_a;
    logic [15:0] processor_mode_status_b;
    core_state_type st_a;
    core_state_type st_b;
    logic [1:0] host_cnt;
    logic host_ready;
    logic hrst_q;
    logic a_rst_q;
    logic b_rst_q;
    logic soft_hold_a;
    logic soft_hold_b;
    logic lockstep;
    logic strapped;
    logic clk_bypass;
    logic ext_wr_err;
    logic [31:0] rdata;
  } state_type;

  state_type r;
  state_type next_r;
  mem_route_type ra;
  mem_route_type rb;
  logic apb_access;
  logic addr_ok;
  logic [15:0] d16;

  // Decode one request against a mode register; shared by both cores.
  function automatic mem_route_type decode(input mem_req_type q,
                                           input logic [15:0] pm);
    mem_route_type o;
    logic [15:0] lo;
    logic hit;
    o = '0;
    lo = q.addr[15:0];
    hit = 1'b0;
    case (q.space)
      space_prog:
      begin
        if ((q.addr >= pgm_only1_lo && q.addr <= pgm_only1_hi) ||
            (q.addr >= pgm_only2_lo && q.addr <= pgm_only2_hi))
          hit = 1'b1;
        else if (lo >= sa2_lo)
          hit = ~pm[map_sel_bit];
        else if (q.addr[17:16] == 2'h0 && lo >= dual_lo && lo <= sa1_hi)
          hit = pm[overlay_bit];
        o.internal = q.valid & hit;
        o.external = q.valid & ~hit;
      end
      space_data:
      begin
        if (lo >= dual_lo && lo <= sa1_hi)
          hit = 1'b1;
        else if (lo >= sa2_lo)
          hit = pm[data_view_bit];
        o.internal = q.valid & hit;
        o.external = q.valid & ~hit;
      end
      space_io:
      begin
        o.external = q.valid;
        o.io_strobe = q.valid;
      end
      default:
      begin
        o = '0;
      end
    endcase
    return o;
  endfunction

  // Routing of each core, gated by its run state.
  // Per-subsystem map
  assign ra = (r.st_a != core_held) ? decode(req_a, r.processor_mode_status_a) : '0;
  assign rb = (r.st_b != core_held) ? decode(req_b, r.processor_mode_status_b) : '0;
  assign route_a = ra;
  assign route_b = rb;

  // Shared pins: only the owner reaches them; valid, write and io strobe only in memory mode.
  // Owner gating
  always_comb
  begin
    mem_req_type own;
    mem_route_type orr;
    own = external_memory_interface_owner_select ? req_b : req_a;
    orr = external_memory_interface_owner_select ? rb : ra;
    ext_valid = external_memory_interface_hpi_select & orr.external;
    ext_write = external_memory_interface_hpi_select & orr.external & own.write & ~r.lockstep;
    ext_addr = own.addr;
    ext_is_io = orr.io_strobe;
    io_space_strobe = external_memory_interface_hpi_select & orr.io_strobe;
  end

  assign host_port_active = ~external_memory_interface_hpi_select;
  assign host_port_ready = r.host_ready;
  assign core_a_running = (r.st_a == core_run);
  assign core_b_running = (r.st_b == core_run);
  assign core_a_fetch_addr = (r.st_a == core_fetch) ? reset_vector : '0;
  assign core_b_fetch_addr = (r.st_b == core_fetch) ? reset_vector : '0;
  assign clock_bypass = r.clk_bypass;
  assign prdata = r.rdata;
  assign pready = 1'b1;
  assign apb_access = psel & penable;
  assign addr_ok = (paddr == processor_mode_status_a_off) || (paddr == processor_mode_status_b_off) ||
                   (paddr == status_off) || (paddr == ctrl_off);
  assign pslverr = apb_access & ~addr_ok;
  assign d16 = pwdata[15:0];

  // Next state: straps, reset sequencing, register writes and reads.
  always_comb
  begin
    logic map_a;
    logic map_b;
    logic host_rise;
    logic rel_write;
    next_r = r;
    map_a = 1'b0;
    map_b = 1'b0;
    host_rise = host_port_reset_n & ~r.hrst_q;
    rel_write = r.host_ready & host_write & (host_addr == release_addr) &
                ~external_memory_interface_hpi_select;
    next_r.hrst_q = host_port_reset_n;
    next_r.a_rst_q = subsystem_a_reset_n;
    next_r.b_rst_q = subsystem_b_reset_n;
    if (!external_memory_interface_hpi_select)
    begin
      map_a = 1'b0;
      map_b = 1'b0;
    end
    else if (!host_port_mux_mode)
    begin
      map_a = 1'b1;
      map_b = 1'b1;
    end
    else
    begin
      map_a = ~external_memory_interface_owner_select;
      map_b = external_memory_interface_owner_select;
    end
    if (!r.strapped)
    begin
      next_r.processor_mode_status_a[map_sel_bit] = map_a;
      next_r.processor_mode_status_b[map_sel_bit] = map_b;
      next_r.strapped = 1'b1;
    end
    if (!host_port_reset_n)
    begin
      next_r.host_cnt = '0;
      next_r.host_ready = 1'b0;
    end
    else if (!r.host_ready)
    begin
      if (r.host_cnt == 2'(host_wait_cycles - 1))
        next_r.host_ready = 1'b1;
      else
        next_r.host_cnt = r.host_cnt + 2'h1;
    end
    // Resets high at host port release
    if (host_rise && subsystem_a_reset_n && subsystem_b_reset_n)
    begin
      if (external_memory_interface_hpi_select && !host_port_mux_mode)
        next_r.lockstep = 1'b1;
      else
      begin
        next_r.soft_hold_a = 1'b1;
        next_r.soft_hold_b = 1'b1;
      end
    end
    if (rel_write)
    begin
      if (external_memory_interface_owner_select)
        next_r.soft_hold_b = 1'b0;
      else
        next_r.soft_hold_a = 1'b0;
    end
    case (r.st_a)
      core_held:
        if (subsystem_a_reset_n && r.a_rst_q && !next_r.soft_hold_a &&
            host_port_reset_n)
          next_r.st_a = core_fetch;
      core_fetch:
        next_r.st_a = core_run;
      core_run:
        next_r.st_a = core_run;
      default:
        next_r.st_a = core_held;
    endcase
    case (r.st_b)
      core_held:
        if (subsystem_b_reset_n && r.b_rst_q && !next_r.soft_hold_b &&
            host_port_reset_n)
          next_r.st_b = core_fetch;
      core_fetch:
        next_r.st_b = core_run;
      core_run:
        next_r.st_b = core_run;
      default:
        next_r.st_b = core_held;
    endcase
    // Subsystem reset clears state; A also clock bypass
    if (!subsystem_a_reset_n)
    begin
      next_r.st_a = core_held;
      next_r.processor_mode_status_a = processor_mode_status_reset;
      next_r.processor_mode_status_a[map_sel_bit] = map_a;
      next_r.clk_bypass = 1'b1;
      next_r.lockstep = 1'b0;
    end
    else if (r.st_a == core_run)
      next_r.clk_bypass = 1'b0;
    if (!subsystem_b_reset_n)
    begin
      next_r.st_b = core_held;
      next_r.processor_mode_status_b = processor_mode_status_reset;
      next_r.processor_mode_status_b[map_sel_bit] = map_b;
    end
    // Lockstep write attempts are flagged for software.
    if (r.lockstep && ext_valid && (external_memory_interface_owner_select ? req_b.write :
        req_a.write))
      next_r.ext_wr_err = 1'b1;
    if (apb_access && pwrite)
    begin
      case (paddr)
        processor_mode_status_a_off:
          next_r.processor_mode_status_a = d16;
        processor_mode_status_b_off:
          next_r.processor_mode_status_b = d16;
        ctrl_off:
        begin
          if (pwdata[0])
            next_r.ext_wr_err = 1'b0;
          if (pwdata[1])
            next_r.lockstep = 1'b0;
        end
        default:
          next_r.rdata = r.rdata;
      endcase
    end
    // Readback, captured in the setup cycle so data is valid at access.
    if (psel && !penable && !pwrite)
    begin
      case (paddr)
        processor_mode_status_a_off:
          next_r.rdata = {16'h0000, r.processor_mode_status_a};
        processor_mode_status_b_off:
          next_r.rdata = {16'h0000, r.processor_mode_status_b};
        status_off:
          next_r.rdata = {22'h000000, r.ext_wr_err, r.lockstep,
                          r.soft_hold_b, r.soft_hold_a, r.host_ready,
                          r.clk_bypass, r.st_b, r.st_a};
        ctrl_off:
          next_r.rdata = 32'h00000000;
        default:
          next_r.rdata = 32'h00000000;
      endcase
    end
    // Error flag set wins over a same-cycle clear.
    if (r.lockstep && ext_valid && (external_memory_interface_owner_select ? req_b.write :
        req_a.write))
      next_r.ext_wr_err = 1'b1;
  end

  // State register; strap bits are taken by the clocked process after
  // release since an async reset may only load constants.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      r <= '{processor_mode_status_a: processor_mode_status_reset, processor_mode_status_b: processor_mode_status_reset, st_a: core_held,
             st_b: core_held, clk_bypass: 1'b1, rdata: 32'h00000000,
             default: 1'b0};
    end
    else
    begin
      r <= next_r;
    end
  end

endmodule

// *** testbench/boot_ctrl_sva.sv ***
// Purpose: Port checks for boot_ctrl.
// Assumes: One clock domain with an asynchronous high reset.
// Notes: Watches routing, ownership, reset and host port timing.
`timescale 1ns/1ns
module boot_ctrl_sva
  import boot_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic external_memory_interface_owner_select,
  input wire logic external_memory_interface_hpi_select,
  input wire logic subsystem_a_reset_n,
  input wire logic host_port_reset_n,
  input wire boot_ctrl_pkg::mem_req_type req_a,
  input wire boot_ctrl_pkg::mem_req_type req_b,
  input wire boot_ctrl_pkg::mem_route_type route_a,
  input wire logic ext_valid,
  input wire logic [17:0] ext_addr,
  input wire logic ext_is_io,
  input wire logic io_space_strobe,
  input wire logic host_port_active,
  input wire logic host_port_ready,
  input wire logic core_a_running,
  input wire logic [17:0] core_a_fetch_addr,
  input wire logic clock_bypass
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // Pin mode, ownership of the shared pins and on-chip data routing.
  a_host_port_mode: assert property (host_port_active == !external_memory_interface_hpi_select)
    else $error("host port mode wrong");
  a_no_ext_hostmode: assert property (!external_memory_interface_hpi_select |-> !ext_valid)
    else $error("external access in host port mode");
  a_owner_addr: assert property (ext_valid |->
    ext_addr == (external_memory_interface_owner_select ? req_b.addr : req_a.addr))
    else $error("shared pins carry the wrong subsystem");
  a_io_strobe_match: assert property
    (io_space_strobe == (ext_valid && ext_is_io))
    else $error("io strobe wrong");
  a_data_ram_int: assert property (core_a_running && req_a.valid &&
    req_a.space == space_data && req_a.addr <= {2'b00, sa1_hi} &&
    req_a.addr >= {2'b00, dual_lo} |-> route_a.internal && !route_a.external)
    else $error("on-chip data address routed out");

  // Reset and boot sequencing.
  a_fetch_vector: assert property (core_a_fetch_addr != '0 |->
    core_a_fetch_addr == reset_vector ##1 core_a_running)
    else $error("bad fetch address or no run");
  a_held_in_reset: assert property
    (!subsystem_a_reset_n |=> !core_a_running)
    else $error("core runs in reset");
  a_bypass_in_reset: assert property
    (!subsystem_a_reset_n |=> clock_bypass)
    else $error("clock not bypassed in reset");
  a_release_delay: assert property ($rose(subsystem_a_reset_n) |->
    !core_a_running ##1 !core_a_running)
    else $error("core started too soon");
  a_host_wait: assert property ($rose(host_port_reset_n) |->
    !host_port_ready ##1 !host_port_ready ##[1:3] host_port_ready)
    else $error("host port ready timing wrong");

  cover property ($rose(core_a_running));
  cover property (io_space_strobe);
  cover property ($rose(host_port_ready));
endmodule

bind boot_ctrl boot_ctrl_sva chk_u (.*);

// *** testbench/host_model.sv ***
// Purpose: External host on the host port side.
// Assumes: The host never sees a ready flag, only its own timing.
// Notes: Idle address lines show the inverse of the release address.
`timescale 1ns/1ns
module host_model
  import boot_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic hrst_req,
  input wire logic wr_req,
  output logic host_port_reset_n,
  output logic [15:0] host_addr,
  output logic host_write = 1'b0
);
  int cnt = 0;
  logic pend = 1'b0;

  assign host_port_reset_n = hrst_req;

  // wait then release
  // One spare cycle beyond the minimum wait keeps the host legal.
  always @(posedge clk)
  begin
    cnt <= hrst_req ? cnt + 1 : 0;
    host_write <= 1'b0;
    host_addr <= ~release_addr;
    if (wr_req)
      pend <= 1'b1;
    if ((pend || wr_req) && cnt > host_wait_cycles)
    begin
      host_write <= 1'b1;
      host_addr <= release_addr;
      pend <= 1'b0;
    end
  end
endmodule

// *** testbench/test_dual_core_memory_boot_control.sv ***
// Purpose: Self-checking bench for boot_ctrl.
// Assumes: Scenarios run in order and share state.
// Notes: Subsystem resets are driven here in the host's place.
`timescale 1ns/1ns
module test_dual_core_memory_boot_control;
  import boot_ctrl_pkg::*;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic pready, pslverr, host_write, host_port_reset_n;
  logic external_memory_interface_owner_select = 0, external_memory_interface_hpi_select = 1;
  logic host_port_mux_mode = 1, hrst_req = 0, wr_req = 0;
  logic subsystem_a_reset_n = 0, subsystem_b_reset_n = 0;
  logic [15:0] host_addr;
  mem_req_type req_a = '0, req_b = '0;
  mem_route_type route_a, route_b;
  logic ext_valid, ext_write, ext_is_io, io_space_strobe;
  logic [17:0] ext_addr, core_a_fetch_addr, core_b_fetch_addr;
  logic host_port_active, host_port_ready, clock_bypass;
  logic core_a_running, core_b_running;
  int errors = 0, checks = 0;

  boot_ctrl dut_u (.*);
  host_model host_u (.*);

  // Free-running 20 MHz clock.
  initial
    forever #25 clk = ~clk;

  task automatic cmp(string m, logic [31:0] g, logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      errors++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask

  // Request is held until pready is seen high at a rising edge.
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1, a, d, r, e);
  endtask

  task automatic rd(logic [7:0] a, logic [31:0] x, logic ex);
    logic [31:0] r;
    logic e;
    apb(0, a, 0, r, e);
    cmp("read data", r, x);
    cmp("read error", e, ex);
  endtask

  task automatic release_one(logic o);
    @(posedge clk);
    external_memory_interface_owner_select <= o;
    wr_req <= 1;
    @(posedge clk);
    wr_req <= 0;
  endtask

  task automatic t_mode;
    rd(processor_mode_status_a_off, 32'h0000FFC0, 0);
    rd(processor_mode_status_b_off, 32'h0000FF80, 0);
    // A subsystem held in reset keeps reloading its mode register.
    wr(processor_mode_status_a_off, 32'hFFFF0068);
    rd(processor_mode_status_a_off, 32'h0000FFC0, 0);
    rd(8'h10, 32'h0, 1);
  endtask

  // Cores stay held until the host writes the release address.
  task automatic t_soft;
    @(posedge clk);
    external_memory_interface_hpi_select <= 0;
    subsystem_a_reset_n <= 1;
    subsystem_b_reset_n <= 1;
    hrst_req <= 1;
    repeat (10) @(negedge clk);
    cmp("held", {core_a_running, core_b_running}, 2'b00);
    release_one(0);
    repeat (20) @(negedge clk) if (core_a_running === 1'b1) break;
    cmp("a freed", {core_a_running, core_b_running}, 2'b10);
    release_one(1);
    repeat (20) @(negedge clk) if (core_b_running === 1'b1) break;
    cmp("b freed", core_b_running, 1);
  endtask

  task automatic t_route;
    wr(processor_mode_status_a_off, 32'hFFFF0068);
    rd(processor_mode_status_a_off, 32'h00000068, 0);
    wr(processor_mode_status_a_off, 32'h0);
    external_memory_interface_hpi_select <= 1;
    external_memory_interface_owner_select <= 0;
    req_a <= '{1'b1, space_data, 1'b0, 18'h04100};
    @(negedge clk);
    cmp("low ram", route_a, 3'b100);
    @(posedge clk);
    req_a.addr <= 18'h09000;
    @(negedge clk);
    cmp("ext data", {route_a, ext_valid}, 4'b0101);
    cmp("ext addr", ext_addr, 18'h09000);
    @(posedge clk);
    external_memory_interface_owner_select <= 1;
    req_b <= '{1'b1, space_io, 1'b1, 18'h00123};
    @(negedge clk);
    cmp("io", {io_space_strobe, ext_is_io, ext_write}, 3'b111);
    cmp("owner b", ext_addr, 18'h00123);
    wr(processor_mode_status_a_off, 32'h8);
    rd(processor_mode_status_a_off, 32'h00000008, 0);
    @(negedge clk);
    cmp("data view", route_a, 3'b100);
    @(posedge clk);
    external_memory_interface_hpi_select <= 0;
    @(negedge clk);
    cmp("host mode", {host_port_active, ext_valid}, 2'b10);
  endtask

  task automatic t_boot;
    logic seen;
    @(posedge clk);
    subsystem_a_reset_n <= 0;
    subsystem_b_reset_n <= 0;
    external_memory_interface_hpi_select <= 1;
    host_port_mux_mode <= 0;
    repeat (3) @(negedge clk);
    cmp("stopped", {core_a_running, clock_bypass}, 2'b01);
    rd(processor_mode_status_a_off, 32'h0000FFC0, 0);
    rd(processor_mode_status_b_off, 32'h0000FFC0, 0);
    @(posedge clk);
    host_port_mux_mode <= 1;
    external_memory_interface_owner_select <= 0;
    subsystem_a_reset_n <= 1;
    seen = 0;
    repeat (20) @(negedge clk) seen |= core_a_fetch_addr === reset_vector;
    cmp("a vector", seen, 1);
    cmp("a only", {core_a_running, core_b_running, clock_bypass},
        3'b100);
    // hand interface over, then free slave
    @(posedge clk);
    external_memory_interface_owner_select <= 1;
    @(posedge clk);
    subsystem_b_reset_n <= 1;
    seen = 0;
    repeat (20) @(negedge clk) seen |= core_b_fetch_addr === reset_vector;
    cmp("b vector", {seen, core_b_running}, 2'b11);
  endtask

  // Lockstep mode blocks writes until software clears it.
  task automatic t_lock;
    @(posedge clk);
    hrst_req <= 0;
    host_port_mux_mode <= 0;
    external_memory_interface_hpi_select <= 1;
    repeat (2) @(posedge clk);
    hrst_req <= 1;
    repeat (3) @(negedge clk);
    cmp("lockstep", {ext_valid, ext_write}, 2'b10);
    wr(ctrl_off, 32'h2);
    @(negedge clk);
    cmp("unlocked", {ext_valid, ext_write}, 2'b11);
  endtask

  task automatic tally_and_finish;
    if (errors == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Main sequence after a 20-cycle reset.
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 0;
    t_mode;
    t_soft;
    t_route;
    t_boot;
    t_lock;
    tally_and_finish;
  end

  // The whole run needs under two hundred cycles; this cuts a hang short.
  initial
  begin
    repeat (2000) @(posedge clk);
    errors++;
    tally_and_finish;
  end
endmodule
